// file: tbm_bit6_mux.sv
// Purpose : Role mux and samplers for the shared channel 0 transmit bit 6
// Assumes : Pin clocks are far slower than clk (tributary clock ~8 MHz)
// Notes   : Data pin passes two flops, clock pins three; edges are found on synced copies
`timescale 1ns/100ps
`default_nettype none

module tbm_bit6_mux
  import tbm_pkg::*;
#(
  parameter logic [FCNT_W-1:0] FRAME_BITS = FRAME_BITS_DEF
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        shared_bit6_pin,
  input  wire logic        add_bus_clock,
  input  wire logic        tributary_tx_input_clock,
  input  wire logic        add_bus_enable,
  input  wire logic        packet_mode_sel,
  input  wire logic        clear_mode_sel,
  input  wire logic        framer_overhead_next,
  output var  tbm_sample_t add_bus_bit6,
  output var  tbm_sample_t packet_tx_byte_bit6,
  output var  tbm_sample_t tributary_serial_payload_in,
  output var  logic        packet_tx_byte_clock,
  output var  logic        overhead_slot_indicator,
  output var  logic        frame_end_pulse,
  output var  tbm_role_t   active_role
);

  tbm_state_t st_ff;
  tbm_state_t nxt_st;

  // Priority decode of the configuration into one role
  function automatic tbm_role_t role_of(input logic add_en,
                                        input logic pkt,
                                        input logic clr);
    tbm_role_t r;
    r = TBM_ROLE_IDLE;
    if (add_en) begin
      r = TBM_ROLE_ADD;
    end else if (pkt) begin
      r = TBM_ROLE_PKT;
    end else if (clr) begin
      r = TBM_ROLE_CLEAR;
    end
    return r;
  endfunction : role_of

  logic add_fall;
  logic trib_rise;
  logic pkt_rise;

  assign add_fall  = st_ff.async[2] & ~st_ff.async[1];
  assign trib_rise = ~st_ff.tsync[2] & st_ff.tsync[1];
  assign pkt_rise  = st_ff.prise[1];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.dsync = {st_ff.dsync[0], shared_bit6_pin};
    nxt_st.async = {st_ff.async[1:0], add_bus_clock};
    nxt_st.tsync = {st_ff.tsync[1:0], tributary_tx_input_clock};
    nxt_st.role  = role_of(add_bus_enable, packet_mode_sel,
                           clear_mode_sel);
    nxt_st.add_out.valid = 1'b0;
    nxt_st.pkt_out.valid = 1'b0;
    nxt_st.ser_out.valid = 1'b0;
    nxt_st.prise = {st_ff.prise[0], 1'b0};
    nxt_st.ovh   = 1'b0;
    nxt_st.fend  = 1'b0;

    unique case (st_ff.role)
      TBM_ROLE_ADD: begin
        nxt_st.divcnt = '0;
        nxt_st.pclk   = 1'b0;
        nxt_st.bitcnt = '0;
        if (add_fall) begin
          nxt_st.add_out.valid = 1'b1;
          nxt_st.add_out.data  = st_ff.dsync[1];
        end
      end
      TBM_ROLE_PKT: begin
        nxt_st.bitcnt = '0;
        // Byte clock from a divider; rise is delayed to match data sync
        if (st_ff.divcnt == PKT_HALF_VAL - 8'h01) begin
          nxt_st.divcnt = '0;
          nxt_st.pclk   = ~st_ff.pclk;
          nxt_st.prise[0] = ~st_ff.pclk;
        end else begin
          nxt_st.divcnt = st_ff.divcnt + 8'h01;
        end
        if (pkt_rise) begin
          nxt_st.pkt_out.valid = 1'b1;
          nxt_st.pkt_out.data  = st_ff.dsync[1];
        end
      end
      TBM_ROLE_CLEAR: begin
        nxt_st.divcnt = '0;
        nxt_st.pclk   = 1'b0;
        nxt_st.ovh    = st_ff.ovh;
        nxt_st.fend   = st_ff.fend;
        if (trib_rise) begin
          // A bit in a flagged overhead slot is not payload
          nxt_st.ser_out.valid = ~st_ff.ovh;
          nxt_st.ser_out.data  = st_ff.dsync[1];
          nxt_st.ovh = framer_overhead_next;
          nxt_st.fend = (st_ff.bitcnt == FRAME_BITS - 16'h0001);
          if (st_ff.bitcnt == FRAME_BITS - 16'h0001) begin
            nxt_st.bitcnt = '0;
          end else begin
            nxt_st.bitcnt = st_ff.bitcnt + 16'h0001;
          end
        end
      end
      TBM_ROLE_IDLE: begin
        nxt_st.divcnt = '0;
        nxt_st.pclk   = 1'b0;
        nxt_st.bitcnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '{role: TBM_ROLE_IDLE, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign add_bus_bit6                = st_ff.add_out;
  assign packet_tx_byte_bit6         = st_ff.pkt_out;
  assign tributary_serial_payload_in = st_ff.ser_out;
  assign packet_tx_byte_clock        = st_ff.pclk;
  assign overhead_slot_indicator     = st_ff.ovh;
  assign frame_end_pulse             = st_ff.fend;
  assign active_role                 = st_ff.role;

  // Checks
  logic [DIV_W-1:0] pclk_run_ff;
  // Cycles since the byte clock last moved; held at zero outside
  // packet role so the first half period after entry is measured too
  always_ff @(posedge clk) begin
    if (reset || st_ff.role != TBM_ROLE_PKT ||
        st_ff.pclk != nxt_st.pclk) begin
      pclk_run_ff <= '0;
    end else if (pclk_run_ff != 8'hff) begin
      pclk_run_ff <= pclk_run_ff + 8'h01;
    end
  end

  add_role_only_a: assert property (@(posedge clk)
    disable iff (reset)
    add_bus_bit6.valid |-> $past(st_ff.role) == TBM_ROLE_ADD)
    else $error("add bus sample outside add role");

  add_fall_a: assert property (@(posedge clk)
    disable iff (reset)
    (st_ff.role == TBM_ROLE_ADD && add_fall)
      |=> add_bus_bit6.valid && add_bus_bit6.data == $past(st_ff.dsync[1]))
    else $error("add bus bit not latched on falling clock");

  pkt_clock_a: assert property (@(posedge clk)
    disable iff (reset)
    ($changed(st_ff.pclk) && $past(st_ff.role) == TBM_ROLE_PKT)
      |-> $past(pclk_run_ff) == PKT_HALF_VAL - 8'h01)
    else $error("byte clock half period wrong");

  pkt_sample_a: assert property (@(posedge clk)
    disable iff (reset)
    ($rose(st_ff.pclk) && st_ff.role == TBM_ROLE_PKT
     && nxt_st.role == TBM_ROLE_PKT)
      |-> ##2 packet_tx_byte_bit6.valid
          && packet_tx_byte_bit6.data == $past(st_ff.dsync[1]))
    else $error("packet bit not sampled after byte clock rise");

  trib_sample_a: assert property (@(posedge clk)
    disable iff (reset)
    (st_ff.role == TBM_ROLE_CLEAR && trib_rise && !st_ff.ovh)
      |=> tributary_serial_payload_in.valid
          && tributary_serial_payload_in.data == $past(st_ff.dsync[1]))
    else $error("payload bit missed on tributary rise");

  ovh_drop_a: assert property (@(posedge clk)
    disable iff (reset)
    (trib_rise && st_ff.ovh) |=> !tributary_serial_payload_in.valid)
    else $error("overhead slot bit taken as payload");

  frame_end_a: assert property (@(posedge clk)
    disable iff (reset)
    (st_ff.role == TBM_ROLE_CLEAR && trib_rise
     && st_ff.bitcnt == FRAME_BITS - 16'h0001)
      |=> frame_end_pulse && st_ff.bitcnt == '0)
    else $error("frame end not raised on last bit");

  frame_end_len_a: assert property (@(posedge clk)
    disable iff (reset)
    (frame_end_pulse && !trib_rise && st_ff.role == TBM_ROLE_CLEAR)
      |=> frame_end_pulse)
    else $error("frame end dropped inside tributary period");

  frame_end_drop_a: assert property (@(posedge clk)
    disable iff (reset)
    (frame_end_pulse && trib_rise && FRAME_BITS > 16'h0001)
      |=> !frame_end_pulse)
    else $error("frame end longer than one tributary period");

  one_role_a: assert property (@(posedge clk)
    disable iff (reset)
    $onehot0({add_bus_bit6.valid, packet_tx_byte_bit6.valid,
              tributary_serial_payload_in.valid}))
    else $error("more than one role produced a sample");

  idle_pclk_a: assert property (@(posedge clk)
    disable iff (reset)
    st_ff.role != TBM_ROLE_PKT
      |=> ##1 (!packet_tx_byte_clock || st_ff.role == TBM_ROLE_PKT))
    else $error("byte clock runs outside packet role");

  add_cov_c: cover property (@(posedge clk) disable iff (reset)
    add_bus_bit6.valid);
  pkt_cov_c: cover property (@(posedge clk) disable iff (reset)
    packet_tx_byte_bit6.valid);
  fend_cov_c: cover property (@(posedge clk) disable iff (reset)
    $rose(frame_end_pulse));
  ovh_cov_c: cover property (@(posedge clk) disable iff (reset)
    trib_rise && st_ff.ovh);

endmodule : tbm_bit6_mux

`default_nettype wire

// file: tbm_pkg.sv
// Purpose : Shared types and constants for the transmit bit-6 role mux
// Assumes : One 200 MHz system clock samples every pin of the block
// Notes   : Role select inputs come from configuration logic on clk
//
// Overview of operation
// - With the add bus enabled the shared pin is bit 6 of the add bus.
// - In add bus role the bit is latched on each falling add clock edge.
// - With add bus off and packet mode set the pin is packet byte bit 6 and a byte clock is driven out.
// - In packet role the bit is sampled on each rising edge of the driven byte clock.
// - In clear-channel role the bit is sampled on each rising tributary clock edge.
// - The frame end output is high for one tributary clock period on a frame's last bit.
package tbm_pkg;

  localparam int unsigned CLK_NS      = 5;
  localparam int unsigned PKT_HALF_NS = 40;
  localparam int unsigned PKT_HALF_CYC =
    (PKT_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DIV_W       = 8;
  localparam int unsigned FCNT_W      = 16;
  localparam logic [FCNT_W-1:0] FRAME_BITS_DEF = 16'h0400;
  localparam logic [DIV_W-1:0] PKT_HALF_VAL = DIV_W'(PKT_HALF_CYC);

  typedef enum logic [1:0] {
    TBM_ROLE_IDLE,
    TBM_ROLE_ADD,
    TBM_ROLE_PKT,
    TBM_ROLE_CLEAR
  } tbm_role_t;

  typedef struct packed {
    logic valid;
    logic data;
  } tbm_sample_t;

  typedef struct packed {
    logic [1:0]        dsync;
    logic [2:0]        async;
    logic [2:0]        tsync;
    logic [DIV_W-1:0]  divcnt;
    logic              pclk;
    logic [1:0]        prise;
    logic [FCNT_W-1:0] bitcnt;
    tbm_role_t         role;
    tbm_sample_t       add_out;
    tbm_sample_t       pkt_out;
    tbm_sample_t       ser_out;
    logic              fend;
    logic              ovh;
  } tbm_state_t;

endpackage : tbm_pkg

// file: tbm_term_model.sv
// Purpose : Terminal equipment model driving the shared transmit pin
// Assumes : Add and tributary clocks share one 125 ns waveform, inverted
// Notes   : Link clocks stand still, tributary low, unless run outside packet
`timescale 1ns/100ps
`default_nettype none

module tbm_term_model
  import tbm_pkg::*;
(
  input  wire logic      run,
  input  wire tbm_role_t role,
  input  wire logic      rnd_bit,
  input  wire logic      packet_tx_byte_clock,
  input  wire logic      overhead_slot_indicator,
  output var  logic      shared_bit6_pin,
  output var  logic      add_bus_clock,
  output var  logic      tributary_tx_input_clock,
  output var  logic      note_tgl,
  output var  logic      note_bit
);
  logic payload;
  initial begin
    shared_bit6_pin = 1'b0;
    add_bus_clock = 1'b1;
    tributary_tx_input_clock = 1'b0;
    note_tgl = 1'b0;
    note_bit = 1'b0;
    payload = 1'b1;
  end
  always begin
    #62.5;
    // Tributary and add clocks rest in packet role so only one clock moves
    if ((run && role != TBM_ROLE_PKT) || tributary_tx_input_clock) begin
      tributary_tx_input_clock = ~tributary_tx_input_clock;
      add_bus_clock = ~tributary_tx_input_clock;
    end
  end
  // Data moves on the edge away from each role's sampling edge
  always @(negedge tributary_tx_input_clock or
           negedge packet_tx_byte_clock) begin
    payload = !(role == TBM_ROLE_CLEAR && overhead_slot_indicator);
    shared_bit6_pin = payload ? rnd_bit : ~shared_bit6_pin;
  end
  // Report each bit the device is due to take
  always @(posedge tributary_tx_input_clock or
           posedge packet_tx_byte_clock) begin
    if (role == TBM_ROLE_ADD || role == TBM_ROLE_PKT ||
        (role == TBM_ROLE_CLEAR && payload)) begin
      note_bit = shared_bit6_pin;
      note_tgl = ~note_tgl;
    end
  end
endmodule : tbm_term_model
`default_nettype wire

// file: test_tx_channel_input_bit6_mux.sv
// Purpose : Self-checking bench for the transmit bit-6 role mux
// Assumes : Frame length cut to 8 bits
// Notes   : Model notes due bits; a watcher matches them to valid pulses
`timescale 1ns/100ps
`default_nettype none

module test_tx_channel_input_bit6_mux import tbm_pkg::*;;
  logic clk, reset, pin, aclk, tclk, add_en, pkt_sel, clr_sel, ovh_next;
  logic run, rnd_bit, note_tgl, note_bit, pclk, ovh_ind, fend;
  logic        seen_bit, exp_ovh;
  logic [2:0]  tsh;
  tbm_sample_t add_s, pkt_s, ser_s;
  tbm_role_t   act_role, exp_role;
  int          error_cnt, check_count, cyc, rise_cnt;
  integer      seed;
  logic        exp_q [$];
  realtime     t0;
  logic [2:0]  cfg_tab [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h0};
  tbm_role_t   role_tab [6] = '{TBM_ROLE_ADD, TBM_ROLE_ADD, TBM_ROLE_PKT,
                                TBM_ROLE_PKT, TBM_ROLE_CLEAR, TBM_ROLE_IDLE};

  tbm_bit6_mux #(.FRAME_BITS(16'h0008)) i_tbm_bit6_mux (
    .clk(clk), .reset(reset), .shared_bit6_pin(pin), .add_bus_clock(aclk),
    .tributary_tx_input_clock(tclk), .add_bus_enable(add_en),
    .packet_mode_sel(pkt_sel), .clear_mode_sel(clr_sel),
    .framer_overhead_next(ovh_next), .add_bus_bit6(add_s),
    .packet_tx_byte_bit6(pkt_s), .tributary_serial_payload_in(ser_s),
    .packet_tx_byte_clock(pclk), .overhead_slot_indicator(ovh_ind),
    .frame_end_pulse(fend), .active_role(act_role));
  tbm_term_model i_tbm_term_model (
    .run(run), .role(exp_role), .rnd_bit(rnd_bit),
    .packet_tx_byte_clock(pclk), .overhead_slot_indicator(ovh_ind),
    .shared_bit6_pin(pin), .add_bus_clock(aclk),
    .tributary_tx_input_clock(tclk), .note_tgl(note_tgl),
    .note_bit(note_bit));

  task automatic chk(input logic [2:0] seen, input logic [2:0] exp,
                     input string what);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    #1;
    rnd_bit = 1'($random(seed));
    ovh_next = ($random(seed) & 3) == 0;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  always @(note_tgl) if (!reset) exp_q.push_back(note_bit);
  // Watcher: only the active role may deliver, in model order
  always @(posedge clk) begin
    if (add_s.valid === 1'b1 || pkt_s.valid === 1'b1 ||
        ser_s.valid === 1'b1) begin
      chk({add_s.valid, pkt_s.valid, ser_s.valid},
          {exp_role == TBM_ROLE_ADD, exp_role == TBM_ROLE_PKT,
           exp_role == TBM_ROLE_CLEAR}, "valid");
      // Data of an idle role holds its last sample, so take the valid one
      seen_bit = add_s.valid ? add_s.data
                 : (pkt_s.valid ? pkt_s.data : ser_s.data);
      if (exp_q.size() == 0) chk(3'h1, 3'h0, "extra bit");
      else chk(seen_bit, exp_q.pop_front(), "bit6");
    end
  end
  // Own copy of the tributary edge finder: overhead flag due per rise
  always @(posedge clk) begin
    tsh <= {tsh[1:0], tclk};
    if (tsh[2:1] == 2'b01) exp_ovh <= ovh_next;
  end
  always @(posedge tclk) begin
    if (exp_role == TBM_ROLE_CLEAR) begin
      #60;
      chk(fend, rise_cnt % 8 == 7, "frame end");
      chk(ovh_ind, exp_ovh, "overhead");
      rise_cnt++;
    end else begin
      rise_cnt = 0;
    end
  end

  initial begin
    seed = 32'hd8e5a008;
    clk = 1'b0;
    reset = 1'b1;
    {add_en, pkt_sel, clr_sel, ovh_next, run, rnd_bit} = 6'h00;
    exp_role = TBM_ROLE_IDLE;
    repeat (16) @(posedge clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      #1 {add_en, pkt_sel, clr_sel} = cfg_tab[i];
      exp_role = role_tab[i];
      repeat (4) @(posedge clk);
      chk(3'(act_role), 3'(role_tab[i]), "role");
      #1 run = 1'b1;
      repeat (600) @(posedge clk);
      #1 run = 1'b0;
      if (role_tab[i] == TBM_ROLE_PKT) begin
        @(posedge pclk) t0 = $realtime;
        @(posedge pclk) t0 = $realtime - t0;
        chk(t0 == 2 * PKT_HALF_CYC * CLK_NS, 1, "byte period");
        @(negedge pclk);
      end
      // Leave packet role before the next byte clock rise, none half noted
      repeat ((role_tab[i] == TBM_ROLE_PKT) ? 4 : 40) @(posedge clk);
      #1 {add_en, pkt_sel, clr_sel} = 3'h0;
      exp_role = TBM_ROLE_IDLE;
      repeat (60) @(posedge clk);
      chk(exp_q.size() == 0, 1, "pending bits");
      chk(pclk, 0, "byte clock idle");
    end
    summarize();
  end
endmodule : test_tx_channel_input_bit6_mux
`default_nettype wire
